// file: rtl/cev_avs.sv
// avalon-mm slave handshake for the comparator event registers
// assumes the master holds a request until waitrequest is sampled low
`timescale 1ns/1ps
module cev_avs
    import cev_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // bus request
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_rdata,
    // bus answer
    output logic o_waitrequest,
    output logic [31:0] o_readdata,
    output logic o_wr_commit
);
    logic ack_ff;
    logic [31:0] rdata_ff;

    // ****************************************
    // one wait state per access
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (i_read | i_write) & ~ack_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_ff <= REG_RST;
        end else if (i_read && !ack_ff) begin
            rdata_ff <= i_rdata;
        end
    end

    assign o_waitrequest = (i_read | i_write) & ~ack_ff;
    assign o_readdata = rdata_ff;
    assign o_wr_commit = i_write & ack_ff;

endmodule : cev_avs

// file: rtl/cev_pkg.sv
// constants for the comparator event output block
// assumes a 32-bit avalon-mm register bus and a single system clock
package cev_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFS_IRQ_CAUSE = 8'h04;
    localparam logic [7:0] OFS_MAIN_STATUS = 8'h08;
    localparam logic [7:0] OFS_TERM_ENV = 8'h0C;
    localparam logic [7:0] OFS_CMP_ENV = 8'h10;
    localparam logic [7:0] OFS_CMP5_ENV = 8'h14;
    localparam logic [7:0] OFS_PRESET_MULT = 8'h18;
    localparam logic [7:0] OFS_ACTIVE_MULT = 8'h1C;
    localparam logic [7:0] OFS_GP_TERM = 8'h20;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int NUM_CMP = 5;
    localparam int CMP_EVT_LSB = 8;
    localparam int ACT_LSB_1 = 5;
    localparam int ACT_LSB_2 = 13;
    localparam int ACT_LSB_3 = 21;
    localparam int ACT_LSB_4 = 30;
    localparam int ACT_LSB_5 = 6;
    localparam int TERM1_MODE_LSB = 6;
    localparam int TERM2_MODE_LSB = 8;
    localparam int GP_IN_LSB = 8;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // ****************************************
    // encodings
    // ****************************************
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_STOP_NOW = 2'b01,
        ACT_DEC_STOP = 2'b10,
        ACT_RELOAD = 2'b11
    } cev_act_e;

    typedef enum logic [1:0] {
        TERM_GP_IN = 2'b00,
        TERM_GP_OUT = 2'b01,
        TERM_MATCH_LO = 2'b10,
        TERM_MATCH_HI = 2'b11
    } cev_term_e;

    // byte-enable merge of a write into a stored word
    function automatic logic [31:0] cev_be_merge(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : cev_be_merge

endpackage : cev_pkg

// file: rtl/cev_term.sv
// one shared general-purpose / comparator match terminal
// assumes the pin input is already synchronised
`timescale 1ns/1ps
module cev_term
    import cev_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // control
    input wire logic [1:0] i_mode,
    input wire logic i_gp_out,
    input wire logic i_match,
    // pin
    output logic o_pin,
    output logic o_pin_oe_n
);
    // ****************************************
    // mode decode, registered pin drive
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pin <= 1'b0;
            o_pin_oe_n <= 1'b1;
        end else begin
            case (i_mode)
                TERM_GP_IN: begin
                    o_pin <= 1'b0;
                    o_pin_oe_n <= 1'b1;
                end
                TERM_GP_OUT: begin
                    o_pin <= i_gp_out;
                    o_pin_oe_n <= 1'b0;
                end
                TERM_MATCH_LO: begin
                    o_pin <= ~i_match;
                    o_pin_oe_n <= 1'b0;
                end
                default: begin
                    o_pin <= i_match;
                    o_pin_oe_n <= 1'b0;
                end
            endcase
        end
    end

endmodule : cev_term

// file: rtl/cev_top.sv
// comparator event outputs: match actions, interrupt cause, status, terminals
// assumes comparator match levels come from logic on i_clk
//
// Operation
// R1 - selectors for comparators 1-4 in compare_env_config bits 5-6,13-14,21-22,30-31
// R2 - selector for comparator 5 in compare5_env_config bits 6-7
// R3 - selector: 00 nothing, 01 immediate stop, 10 decel stop, 11 reload
// R4 - no-action match still feeds interrupt, terminal output and sync event
// R5 - software should use reload to change speed during motion
// R6 - reload also copies preset multiplier into active multiplier
// R7 - interrupt output low on enabled comparator match, enables at bits 8-12
// R8 - cause flags for comparators 1-5 at irq_cause bits 8-12
// R9 - live match conditions at main_status_word bits 8-12
// R10 - comparator 1 terminal mode: input, output, match low, match high
// R11 - comparator 2 terminal mode in bits 8-9: 00 input, 01 output
// R12 - comparator 2 terminal: 10 match low, 11 match high
// R13 - cause flags stick until cleared; interrupt holds while any enabled flag
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module cev_top
    import cev_pkg::*;
#(
    parameter int MULT_W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // comparator matches
    input wire logic [NUM_CMP-1:0] i_cmp_match,
    // motion requests
    output logic o_stop_now,
    output logic o_dec_stop,
    output logic o_preload,
    output logic [NUM_CMP-1:0] o_match_evt,
    output logic [MULT_W-1:0] o_active_multiplier,
    // interrupt
    output logic o_irq_n,
    // shared terminals: pos_soft_limit / cmp1, neg_soft_limit / cmp2
    input wire logic [1:0] i_term_in,
    output logic [1:0] o_term_out,
    output logic [1:0] o_term_oe_n
);
    // ****************************************
    // registers
    // ****************************************
    logic [31:0] irq_enable_ff;
    logic [31:0] term_env_ff;
    logic [31:0] cmp_env_ff;
    logic [31:0] cmp5_env_ff;
    logic [MULT_W-1:0] preset_multiplier_ff;
    logic [MULT_W-1:0] active_multiplier_ff;
    logic [1:0] gp_out_ff;
    logic [NUM_CMP-1:0] cause_ff;
    logic [NUM_CMP-1:0] match_d_ff;
    logic [1:0] term_s1_ff;
    logic [1:0] term_s2_ff;
    logic stop_now_ff;
    logic dec_stop_ff;
    logic preload_ff;
    logic [NUM_CMP-1:0] match_evt_ff;
    logic irq_n_ff;

    logic wr_commit;
    logic [31:0] rd_mux;
    logic [NUM_CMP-1:0] evt;
    logic [NUM_CMP-1:0] irq_en;
    logic [NUM_CMP-1:0] cause_clr;
    logic [NUM_CMP-1:0] want_stop;
    logic [NUM_CMP-1:0] want_dec;
    logic [NUM_CMP-1:0] want_load;
    logic [1:0] sel [NUM_CMP];
    logic [15:0] main_status_word;

    // ****************************************
    // bus slave
    // ****************************************
    cev_avs u_avs (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_read(i_avs_read),
        .i_write(i_avs_write),
        .i_rdata(rd_mux),
        .o_waitrequest(o_avs_waitrequest),
        .o_readdata(o_avs_readdata),
        .o_wr_commit(wr_commit)
    );

    function automatic logic wr_at(input logic [7:0] ofs);
        return wr_commit && (i_avs_address == ofs);
    endfunction : wr_at

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_enable_ff <= REG_RST;
            term_env_ff <= REG_RST;
            cmp_env_ff <= REG_RST;
            cmp5_env_ff <= REG_RST;
            gp_out_ff <= 2'h0;
        end else begin
            if (wr_at(OFS_IRQ_ENABLE)) begin
                irq_enable_ff <= cev_be_merge(irq_enable_ff, i_avs_writedata, i_avs_byteenable);
            end
            if (wr_at(OFS_TERM_ENV)) begin
                term_env_ff <= cev_be_merge(term_env_ff, i_avs_writedata, i_avs_byteenable);
            end
            if (wr_at(OFS_CMP_ENV)) begin
                cmp_env_ff <= cev_be_merge(cmp_env_ff, i_avs_writedata, i_avs_byteenable);
            end
            if (wr_at(OFS_CMP5_ENV)) begin
                cmp5_env_ff <= cev_be_merge(cmp5_env_ff, i_avs_writedata, i_avs_byteenable);
            end
            if (wr_at(OFS_GP_TERM) && i_avs_byteenable[0]) begin
                gp_out_ff <= i_avs_writedata[1:0];
            end
        end
    end

    // ****************************************
    // multipliers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            preset_multiplier_ff <= '0;
        end else if (wr_at(OFS_PRESET_MULT)) begin
            preset_multiplier_ff <= MULT_W'(i_avs_writedata);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            active_multiplier_ff <= '0;
        end else if (|want_load) begin
            active_multiplier_ff <= preset_multiplier_ff; // R6
        end
    end

    assign o_active_multiplier = active_multiplier_ff;

    // ****************************************
    // match events and action decode
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            match_d_ff <= '0;
        end else begin
            match_d_ff <= i_cmp_match;
        end
    end

    assign evt = i_cmp_match & ~match_d_ff;
    assign irq_en = irq_enable_ff[CMP_EVT_LSB +: NUM_CMP]; // R7
    assign cause_clr = (wr_commit && (i_avs_address == OFS_IRQ_CAUSE))
        ? i_avs_writedata[CMP_EVT_LSB +: NUM_CMP] : '0;

    assign sel[0] = cmp_env_ff[ACT_LSB_1 +: 2]; // R1
    assign sel[1] = cmp_env_ff[ACT_LSB_2 +: 2]; // R1
    assign sel[2] = cmp_env_ff[ACT_LSB_3 +: 2]; // R1
    assign sel[3] = cmp_env_ff[ACT_LSB_4 +: 2]; // R1
    assign sel[4] = cmp5_env_ff[ACT_LSB_5 +: 2]; // R2

    for (genvar n = 0; n < NUM_CMP; n++) begin : g_cmp
        assign want_stop[n] = evt[n] && (sel[n] == ACT_STOP_NOW); // R3
        assign want_dec[n] = evt[n] && (sel[n] == ACT_DEC_STOP); // R3
        assign want_load[n] = evt[n] && (sel[n] == ACT_RELOAD); // R3 R5
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            stop_now_ff <= 1'b0;
            dec_stop_ff <= 1'b0;
            preload_ff <= 1'b0;
        end else begin
            stop_now_ff <= |want_stop; // R3
            dec_stop_ff <= |want_dec & ~|want_stop; // R3
            preload_ff <= |want_load & ~|want_stop & ~|want_dec; // R3
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            match_evt_ff <= '0;
        end else begin
            match_evt_ff <= evt; // R4
        end
    end

    assign o_stop_now = stop_now_ff;
    assign o_dec_stop = dec_stop_ff;
    assign o_preload = preload_ff;
    assign o_match_evt = match_evt_ff;

    // ****************************************
    // interrupt cause and output
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cause_ff <= '0;
        end else begin
            cause_ff <= (cause_ff & ~cause_clr) | (evt & irq_en); // R8 R13
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= ~|(((cause_ff & ~cause_clr) | (evt & irq_en)) & irq_en); // R7 R13
        end
    end

    assign o_irq_n = irq_n_ff;

    // ****************************************
    // terminals
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            term_s1_ff <= 2'h0;
            term_s2_ff <= 2'h0;
        end else begin
            term_s1_ff <= i_term_in;
            term_s2_ff <= term_s1_ff;
        end
    end

    cev_term u_term1 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_mode(term_env_ff[TERM1_MODE_LSB +: 2]), // R10
        .i_gp_out(gp_out_ff[0]),
        .i_match(i_cmp_match[0]),
        .o_pin(o_term_out[0]),
        .o_pin_oe_n(o_term_oe_n[0])
    );

    cev_term u_term2 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_mode(term_env_ff[TERM2_MODE_LSB +: 2]), // R11 R12
        .i_gp_out(gp_out_ff[1]),
        .i_match(i_cmp_match[1]),
        .o_pin(o_term_out[1]),
        .o_pin_oe_n(o_term_oe_n[1])
    );

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        main_status_word = 16'h0000;
        main_status_word[CMP_EVT_LSB +: NUM_CMP] = i_cmp_match; // R9
        rd_mux = UNMAPPED_RD;
        case (i_avs_address)
            OFS_IRQ_ENABLE: rd_mux = irq_enable_ff;
            OFS_IRQ_CAUSE: rd_mux[CMP_EVT_LSB +: NUM_CMP] = cause_ff; // R8
            OFS_MAIN_STATUS: rd_mux[15:0] = main_status_word;
            OFS_TERM_ENV: rd_mux = term_env_ff;
            OFS_CMP_ENV: rd_mux = cmp_env_ff;
            OFS_CMP5_ENV: rd_mux = cmp5_env_ff;
            OFS_PRESET_MULT: rd_mux[MULT_W-1:0] = preset_multiplier_ff;
            OFS_ACTIVE_MULT: rd_mux[MULT_W-1:0] = active_multiplier_ff;
            OFS_GP_TERM: begin
                rd_mux[1:0] = gp_out_ff;
                rd_mux[GP_IN_LSB +: 2] = term_s2_ff;
            end
            default: rd_mux = UNMAPPED_RD;
        endcase
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_load_evt;
        |want_load && !(|want_stop) && !(|want_dec);
    endsequence

    sequence s_load_done;
        o_preload && (o_active_multiplier == $past(preset_multiplier_ff));
    endsequence

    stop_now_req_a: assert property (|want_stop |=> o_stop_now && !o_dec_stop && !o_preload) // R3
        else $error("stop request missing");
    dec_stop_req_a: assert property (|want_dec && !(|want_stop) |=> o_dec_stop && !o_stop_now) // R3
        else $error("decel stop request missing");
    reload_copy_a: assert property (s_load_evt |=> s_load_done) // R6
        else $error("reload did not copy multiplier");
    no_action_a: assert property (evt != '0 && want_stop == '0 && want_dec == '0 // R4
        && want_load == '0 |=> !o_stop_now && !o_dec_stop && !o_preload
        && o_match_evt == $past(evt))
        else $error("no-action match moved motion");
    irq_assert_a: assert property ((evt & irq_en) != '0 |=> !o_irq_n) // R7
        else $error("interrupt not asserted");
    cause_set_a: assert property (evt[0] && irq_en[0] |=> cause_ff[0]) // R8
        else $error("cause flag not set");
    cause_hold_a: assert property (cause_ff[2] && !cause_clr[2] |=> cause_ff[2]) // R13
        else $error("cause flag lost");
    irq_idle_a: assert property ((cause_ff & irq_en) == '0 && (evt & irq_en) == '0 // R13
        ##1 $stable(irq_enable_ff) |-> o_irq_n)
        else $error("interrupt without cause");
    status_live_a: assert property (i_avs_read && !o_avs_waitrequest // R9
        && i_avs_address == OFS_MAIN_STATUS
        |-> o_avs_readdata[CMP_EVT_LSB +: NUM_CMP] == $past(i_cmp_match))
        else $error("status not live");
    term1_lo_a: assert property (term_env_ff[TERM1_MODE_LSB +: 2] == TERM_MATCH_LO ##1 // R10
        term_env_ff[TERM1_MODE_LSB +: 2] == TERM_MATCH_LO |-> !o_term_oe_n[0]
        && o_term_out[0] == !$past(i_cmp_match[0]))
        else $error("terminal 1 drive wrong");
    term2_mode_a: assert property (term_env_ff[TERM2_MODE_LSB +: 2] == TERM_GP_IN // R11
        |=> o_term_oe_n[1])
        else $error("terminal 2 not input");
    term2_hi_a: assert property (term_env_ff[TERM2_MODE_LSB +: 2] == TERM_MATCH_HI // R12
        |=> !o_term_oe_n[1] && o_term_out[1] == $past(i_cmp_match[1]))
        else $error("terminal 2 drive wrong");
    sel1_stop_a: assert property (evt[0] && cmp_env_ff[ACT_LSB_1 +: 2] == ACT_STOP_NOW // R1
        |=> o_stop_now)
        else $error("comparator 1 selector ignored");
    sel4_dec_a: assert property (evt[3] && cmp_env_ff[ACT_LSB_4 +: 2] == ACT_DEC_STOP // R1
        && !(|want_stop) |=> o_dec_stop)
        else $error("comparator 4 selector ignored");
    sel5_load_a: assert property (evt[4] && cmp5_env_ff[ACT_LSB_5 +: 2] == ACT_RELOAD // R2
        |=> o_active_multiplier == $past(preset_multiplier_ff))
        else $error("comparator 5 reload ignored");
    mult_hold_a: assert property (!(|want_load) |=> $stable(o_active_multiplier)) // R6
        else $error("active multiplier moved without reload");
    match_evt_a: assert property (evt[2] |=> o_match_evt[2]) // R4
        else $error("match event missing");
    cause_block_a: assert property (!cause_ff[3] && !(evt[3] && irq_en[3]) // R8
        |=> !cause_ff[3])
        else $error("cause flag set without enabled match");
    cause_clear_a: assert property (cause_clr[1] && !(evt[1] && irq_en[1]) // R13
        |=> !cause_ff[1])
        else $error("cause flag not cleared");
    term1_in_a: assert property (term_env_ff[TERM1_MODE_LSB +: 2] == TERM_GP_IN // R10
        |=> o_term_oe_n[0])
        else $error("terminal 1 not input");
    term1_out_a: assert property (term_env_ff[TERM1_MODE_LSB +: 2] == TERM_GP_OUT // R10
        |=> !o_term_oe_n[0] && o_term_out[0] == $past(gp_out_ff[0]))
        else $error("terminal 1 output wrong");
    term2_lo_a: assert property (term_env_ff[TERM2_MODE_LSB +: 2] == TERM_MATCH_LO // R12
        |=> !o_term_oe_n[1] && o_term_out[1] == !$past(i_cmp_match[1]))
        else $error("terminal 2 low drive wrong");

endmodule : cev_top

// file: test/cev_host_model.sv
// host cpu model: avalon-mm master for the comparator event registers
// assumes one clock and a slave that stalls with waitrequest
`timescale 1ns/1ps
module cev_host_model
    import cev_pkg::*;
(
    // clock
    input wire logic i_clk,
    // bus answer
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest,
    // bus request
    output logic [ADDR_W-1:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable,
    output logic o_timeout
);
    initial begin
        o_address = '0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = '0;
        o_byteenable = 4'hf;
        o_timeout = 1'b0;
    end

    // one access; speed changes in motion are asked for by reload selection
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        int k;
        k = 0;
        @(posedge i_clk);
        o_address <= a;
        o_writedata <= d;
        o_write <= wr;
        o_read <= ~wr;
        @(posedge i_clk);
        while (i_waitrequest !== 1'b0 && k < 50) begin
            @(posedge i_clk);
            k++;
        end
        q = i_readdata;
        if (k >= 50) o_timeout = 1'b1;
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_writedata <= ~d;
        o_address <= ~a;
    endtask : access
endmodule : cev_host_model

// file: test/comparator_event_outputs_bench.sv
// self-checking bench for the comparator event block
// assumes the host model drives the register bus
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module comparator_event_outputs_bench;
    import cev_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic rd_en, wr_en, wait_rq, tmo;
    logic [31:0] wdata, rdata, q, g, en_w, pre;
    logic [3:0] be;
    logic [4:0] cmp_match = '0;
    logic [1:0] term_in = '0;
    logic stop_now, dec_stop, preload, irq_n;
    logic [4:0] match_evt;
    logic [15:0] act_mult, exp_mult;
    logic [1:0] term_out, term_oe_n;
    int seed = 32'h308d;
    int bad_count = 0;
    int n_tests = 0;
    int lsb[5] = '{5, 13, 21, 30, 6};
    logic [1:0] v;

    always #2 clk = ~clk;

    cev_top DUT (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .i_cmp_match(cmp_match),
        .o_stop_now(stop_now), .o_dec_stop(dec_stop), .o_preload(preload),
        .o_match_evt(match_evt), .o_active_multiplier(act_mult), .o_irq_n(irq_n),
        .i_term_in(term_in), .o_term_out(term_out), .o_term_oe_n(term_oe_n));

    cev_host_model HOST (.i_clk(clk), .i_readdata(rdata), .i_waitrequest(wait_rq),
        .o_address(addr), .o_read(rd_en), .o_write(wr_en), .o_writedata(wdata),
        .o_byteenable(be), .o_timeout(tmo));

    // ****************************************
    // helpers
    // ****************************************
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HOST.access(w, a, d, q);
        if (tmo) begin
            bad_count++;
            print_verdict();
        end
    endtask : bus

    function automatic logic exp_pin(input logic [1:0] m, input logic gv, input logic mv);
        return (m == 2'b01) ? gv : ((m == 2'b10) ? ~mv : mv);
    endfunction : exp_pin

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        exp_mult = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 `CHK("irq_rst", 1'b1, irq_n)
        `CHK("oe_rst", 2'b11, term_oe_n)
        for (int a = 0; a < 6; a++) begin
            bus(1'b0, 8'(a * 4), '0);
            `CHK("reg_rst", 32'h0000_0000, q)
        end
        $display("test reset done");
        for (int n = 0; n < 5; n++) begin
            for (int act = 0; act < 4; act++) begin
                pre = $random(seed);
                en_w = 32'($random(seed) & 1);
                bus(1'b1, OFS_PRESET_MULT, pre);
                bus(1'b1, OFS_CMP_ENV, (n < 4) ? (32'(act) << lsb[n]) : 32'h0);
                bus(1'b1, OFS_CMP5_ENV, (n == 4) ? (32'(act) << lsb[4]) : 32'h0);
                bus(1'b1, OFS_IRQ_ENABLE, en_w << (8 + n));
                @(posedge clk) cmp_match <= 5'(1 << n);
                @(posedge clk);
                #1 `CHK("stop_now", act == 1, stop_now)
                `CHK("dec_stop", act == 2, dec_stop)
                `CHK("preload", act == 3, preload)
                `CHK("match_evt", 5'(1 << n), match_evt)
                `CHK("irq_low", ~en_w[0], irq_n)
                if (act == 3) exp_mult = pre[15:0];
                `CHK("act_mult", exp_mult, act_mult)
                @(posedge clk);
                #1 `CHK("evt_once", 5'h00, match_evt)
                bus(1'b0, OFS_IRQ_CAUSE, '0);
                `CHK("cause", 5'(en_w << n), q[12:8])
                bus(1'b0, OFS_MAIN_STATUS, '0);
                `CHK("status", 5'(1 << n), q[12:8])
                `CHK("irq_hold", ~en_w[0], irq_n)
                bus(1'b1, OFS_IRQ_CAUSE, 32'h0000_1f00);
                #1 `CHK("irq_clr", 1'b1, irq_n)
                @(posedge clk) cmp_match <= '0;
            end
        end
        $display("test match actions done");
        bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 4; m++) begin
                g = $random(seed);
                bus(1'b1, OFS_GP_TERM, g);
                bus(1'b1, OFS_TERM_ENV, 32'(m) << (t ? 8 : 6));
                for (int mv = 0; mv < 2; mv++) begin
                    @(posedge clk) cmp_match <= 5'(mv << t);
                    repeat (2) @(posedge clk);
                    #1 `CHK("oe_n", m == 0, term_oe_n[t])
                    `CHK("oe_other", 1'b1, term_oe_n[1 - t])
                    v = 2'(mv);
                    if (m != 0) `CHK("pin", exp_pin(2'(m), g[t], v[0]), term_out[t])
                end
            end
        end
        @(posedge clk) cmp_match <= '0;
        $display("test terminals done");
        @(posedge clk) term_in <= 2'($random(seed));
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_GP_TERM, '0);
        `CHK("pin_in", term_in, q[9:8])
        g = $random(seed);
        bus(1'b1, OFS_IRQ_ENABLE, g);
        bus(1'b1, 8'h40, ~g);
        bus(1'b0, OFS_IRQ_ENABLE, '0);
        `CHK("enable_rw", g, q)
        bus(1'b0, 8'h40, '0);
        `CHK("unmapped", 32'h0000_0000, q)
        bus(1'b1, OFS_ACTIVE_MULT, ~g);
        bus(1'b0, OFS_ACTIVE_MULT, '0);
        `CHK("mult_ro", exp_mult, q[15:0])
        bus(1'b1, OFS_MAIN_STATUS, 32'hffff_ffff);
        bus(1'b0, OFS_MAIN_STATUS, '0);
        `CHK("status_ro", 5'h00, q[12:8])
        $display("test access kinds done");
        print_verdict();
    end
endmodule : comparator_event_outputs_bench
